/* File: core/etio_map.svh */
// Purpose: Address map, field widths, reset values and filter lengths for etio_top
// Assumes: 32-bit register bus with byte addresses, one aligned word per register
// Notes:   Line n occupies a 16-byte slot at n * ETIO_LINE_STRIDE
`ifndef ETIO_MAP_SVH
`define ETIO_MAP_SVH

// Address decode
`define ETIO_AW            8
`define ETIO_LINE_STRIDE   8'h10
`define ETIO_OFS_IN_CFG    2'h0
`define ETIO_OFS_OUT_CFG   2'h1
`define ETIO_OFS_THRESH    2'h2
`define ETIO_ADDR_STATUS   8'h50

// Field widths of the per-line registers
`define ETIO_IN_CFG_W      13
`define ETIO_OUT_CFG_W     7
`define ETIO_MEAS_W        16

// Reset values: line disabled, rising edge, high sensitivity, no channels, output on
`define ETIO_IN_CFG_RST    13'h0020
`define ETIO_OUT_CFG_RST   7'h00
`define ETIO_THRESH_RST    16'h0000

// Glitch filter length in cycles for each sensitivity
`define ETIO_FILT_LOW      5'h10
`define ETIO_FILT_MID      5'h04
`define ETIO_FILT_HIGH     5'h01
`define ETIO_FILT_W        5

// Pairing responses always act on the first two channels
`define ETIO_PAIR_CHANS    3'h3

`endif

/* File: core/etio_pkg.sv */
// Purpose: Types shared by the external trigger I/O block
// Assumes: etio_map.svh supplies the field widths
// Notes:   Struct layouts match the register bit layouts, msb first
`include "etio_map.svh"

package etio_pkg;

  typedef enum logic [2:0] {
    det_rise  = 3'h0,
    det_fall  = 3'h1,
    det_high  = 3'h2,
    det_low   = 3'h3,
    det_state = 3'h4
  } etio_det_t;

  typedef enum logic [1:0] {
    sens_low  = 2'h0,
    sens_mid  = 2'h1,
    sens_high = 2'h2
  } etio_sens_t;

  typedef enum logic [3:0] {
    resp_on               = 4'h0,
    resp_off              = 4'h1,
    resp_toggle           = 4'h2,
    resp_power            = 4'h3,
    load_const_voltage    = 4'h4,
    load_const_current    = 4'h5,
    load_const_resistance = 4'h6,
    pairing_individual    = 4'h7,
    pairing_series        = 4'h8,
    pairing_parallel      = 4'h9
  } etio_resp_t;

  typedef enum logic [3:0] {
    cond_output_disabled = 4'h0,
    cond_output_enabled  = 4'h1,
    cond_gt_v            = 4'h2,
    cond_lt_v            = 4'h3,
    cond_eq_v            = 4'h4,
    cond_gt_c            = 4'h5,
    cond_lt_c            = 4'h6,
    cond_eq_c            = 4'h7,
    cond_gt_p            = 4'h8,
    cond_lt_p            = 4'h9,
    cond_eq_p            = 4'hA,
    cond_auto            = 4'hB
  } etio_cond_t;

  // Input side configuration, bits [12:0]
  typedef struct packed {
    etio_resp_t resp;
    logic [2:0] chans;
    etio_sens_t sens;
    etio_det_t  dtype;
    logic       en;
  } etio_in_cfg_t;

  // Output side configuration, bits [6:0]
  typedef struct packed {
    logic [1:0] chan;
    etio_cond_t cond;
    logic       en;
  } etio_out_cfg_t;

  // Live readings of one output channel
  typedef struct packed {
    logic [`ETIO_MEAS_W-1:0] volt;
    logic [`ETIO_MEAS_W-1:0] curr;
    logic [`ETIO_MEAS_W-1:0] pow;
  } etio_meas_t;

  // Response command toward the channel controller
  typedef struct packed {
    etio_resp_t action;
    logic [2:0] chans;
  } etio_cmd_t;

endpackage

/* File: core/etio_top.sv */
// Purpose: Trigger logic for five external data lines of a three-channel supply
// Assumes: All inputs synchronous to clk except io_line_in, which is synchronised here
// Notes:   Lowest-numbered firing line wins; the others are dropped for that cycle
// Operation
// - each line picks rise, fall, high, low or state as its trigger event
// - each line holds a channel set; responses act on those channels
// - resistance-load response switches the channel set to constant-resistance load
// - individual pairing response puts channels one and two into independent operation
// - series pairing response puts channels one and two in series
// - parallel pairing response puts channels one and two in parallel
// - each line has low, middle or high input sensitivity
// - every stored line setting reads back exactly as written
// - output side can trigger on channel output disabled or enabled
// - output-state conditions ignore the threshold; the automatic one compares voltage, current and power against it
// - voltage conditions compare channel voltage against threshold by >, <, =
// - each line's input trigger is enabled separately; disabled lines never respond
// - on, off, toggle, power and voltage/current load responses act on channel set
// - current and power conditions compare against threshold by >, <, =
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "etio_map.svh"

module etio_top #(
  parameter int NL = 5,
  parameter int NC = 3
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic [`ETIO_AW-1:0]            addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic [31:0]                         rdata_q,
  input  wire logic [NL-1:0]                  io_line_in,
  output logic [NL-1:0]                       io_line_out_q,
  output logic [NL-1:0]                       io_line_oe_q,
  input  wire logic [NC-1:0]                  ch_out_en,
  input  wire etio_pkg::etio_meas_t           ch_meas [NC],
  output logic                                cmd_valid_q,
  output etio_pkg::etio_cmd_t                 cmd_q
);
  import etio_pkg::*;

  etio_in_cfg_t            in_cfg_q  [NL];
  etio_out_cfg_t           out_cfg_q [NL];
  logic [`ETIO_MEAS_W-1:0] thresh_q  [NL];
  logic [NL-1:0]           sync1_q;
  logic [NL-1:0]           sync2_q;
  logic [NL-1:0]           filt_q;
  logic [NL-1:0]           prev_q;
  logic [NL-1:0]           hit;
  logic [NL-1:0]           cond_met;
  logic [`ETIO_FILT_W-1:0] filt_cnt_q [NL];
  logic [3:0]              line_sel;
  logic [1:0]              reg_sel;
  logic                    line_hit_ok;
  etio_resp_t              sel_resp;
  logic [2:0]              sel_chans;
  logic                    any_hit;

  // Line index and register slot of the current bus address
  assign line_sel    = addr[7:4];
  assign reg_sel     = addr[3:2];
  assign line_hit_ok = (addr[1:0] == 2'h0) && (32'(line_sel) < NL);

  // Configuration writes; unmapped addresses are silently dropped
  always_ff @(posedge clk) begin
    for (int i = 0; i < NL; i++) begin
      if (!resetn) begin
        in_cfg_q[i]  <= etio_in_cfg_t'(`ETIO_IN_CFG_RST);
        out_cfg_q[i] <= etio_out_cfg_t'(`ETIO_OUT_CFG_RST);
        thresh_q[i]  <= `ETIO_THRESH_RST;
      end else if (wr && line_hit_ok && (32'(line_sel) == i)) begin
        if (reg_sel == `ETIO_OFS_IN_CFG) begin
          in_cfg_q[i] <= etio_in_cfg_t'(wdata[`ETIO_IN_CFG_W-1:0]);
        end else if (reg_sel == `ETIO_OFS_OUT_CFG) begin
          out_cfg_q[i] <= etio_out_cfg_t'(wdata[`ETIO_OUT_CFG_W-1:0]);
        end else if (reg_sel == `ETIO_OFS_THRESH) begin
          thresh_q[i] <= wdata[`ETIO_MEAS_W-1:0];
        end
      end
    end
  end

  // Read data stand one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (rd) begin
      rdata_q <= 32'h0;
      if (addr == `ETIO_ADDR_STATUS) begin
        rdata_q <= {22'h0, io_line_out_q, filt_q};
      end else if (line_hit_ok && reg_sel == `ETIO_OFS_IN_CFG) begin
        rdata_q <= {19'h0, in_cfg_q[line_sel[2:0]]};
      end else if (line_hit_ok && reg_sel == `ETIO_OFS_OUT_CFG) begin
        rdata_q <= {25'h0, out_cfg_q[line_sel[2:0]]};
      end else if (line_hit_ok && reg_sel == `ETIO_OFS_THRESH) begin
        rdata_q <= {16'h0, thresh_q[line_sel[2:0]]};
      end
    end
  end

  // Two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= io_line_in;
      sync2_q <= sync1_q;
    end
  end

  // Glitch filter: lower sensitivity needs a longer stable run, which rejects noise
  always_ff @(posedge clk) begin
    for (int i = 0; i < NL; i++) begin
      if (!resetn) begin
        filt_q[i]     <= 1'b0;
        filt_cnt_q[i] <= '0;
      end else if (sync2_q[i] == filt_q[i]) begin
        filt_cnt_q[i] <= '0;
      end else if ((filt_cnt_q[i] + 5'h1) >= filt_len(in_cfg_q[i].sens)) begin
        filt_q[i]     <= sync2_q[i];
        filt_cnt_q[i] <= '0;
      end else begin
        filt_cnt_q[i] <= filt_cnt_q[i] + 5'h1;
      end
    end
  end

  function automatic logic [`ETIO_FILT_W-1:0] filt_len(etio_sens_t s);
    case (s)
      sens_low: filt_len = `ETIO_FILT_LOW;
      sens_mid: filt_len = `ETIO_FILT_MID;
      default:  filt_len = `ETIO_FILT_HIGH;
    endcase
  endfunction

  // Previous filtered level for edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= filt_q;
    end
  end

  // Trigger event per line; edges last one cycle, levels persist
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      case (in_cfg_q[i].dtype)
        det_rise:  hit[i] = filt_q[i] & ~prev_q[i];
        det_fall:  hit[i] = ~filt_q[i] & prev_q[i];
        det_high:  hit[i] = filt_q[i];
        det_low:   hit[i] = ~filt_q[i];
        det_state: hit[i] = filt_q[i] ^ prev_q[i];
        default:   hit[i] = 1'b0;
      endcase
      hit[i] = hit[i] & in_cfg_q[i].en;
    end
  end

  // Lowest-numbered firing line wins when several fire together
  always_comb begin
    sel_resp  = resp_on;
    sel_chans = 3'h0;
    any_hit   = 1'b0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel_resp  = in_cfg_q[i].resp;
        sel_chans = in_cfg_q[i].chans;
        any_hit   = 1'b1;
      end
    end
  end

  // Response command; pairing needs both first channels in the set, else nothing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_valid_q <= 1'b0;
      cmd_q       <= '0;
    end else begin
      cmd_valid_q  <= 1'b0;
      cmd_q.action <= sel_resp;
      cmd_q.chans  <= sel_chans;
      if (sel_resp == pairing_individual || sel_resp == pairing_series ||
          sel_resp == pairing_parallel) begin
        cmd_q.chans <= `ETIO_PAIR_CHANS;
        cmd_valid_q <= any_hit && ((sel_chans & `ETIO_PAIR_CHANS) == `ETIO_PAIR_CHANS);
      end else begin
        cmd_valid_q <= any_hit && (sel_chans != 3'h0);
      end
    end
  end

  // Output-side condition per line against its selected channel
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      logic [1:0]              c;
      logic [`ETIO_MEAS_W-1:0] t;
      etio_meas_t              m;
      c = (32'(out_cfg_q[i].chan) < NC) ? out_cfg_q[i].chan : 2'h0;
      t = thresh_q[i];
      m = ch_meas[c];
      case (out_cfg_q[i].cond)
        cond_output_disabled: cond_met[i] = ~ch_out_en[c];
        cond_output_enabled:  cond_met[i] = ch_out_en[c];
        cond_gt_v:            cond_met[i] = m.volt > t;
        cond_lt_v:            cond_met[i] = m.volt < t;
        cond_eq_v:            cond_met[i] = m.volt == t;
        cond_gt_c:            cond_met[i] = m.curr > t;
        cond_lt_c:            cond_met[i] = m.curr < t;
        cond_eq_c:            cond_met[i] = m.curr == t;
        cond_gt_p:            cond_met[i] = m.pow > t;
        cond_lt_p:            cond_met[i] = m.pow < t;
        cond_eq_p:            cond_met[i] = m.pow == t;
        cond_auto:            cond_met[i] = (m.volt > t) | (m.curr > t) | (m.pow > t);
        default:              cond_met[i] = 1'b0;
      endcase
    end
  end

  // Drive lines only while the output side is enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_line_out_q <= '0;
      io_line_oe_q  <= '0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        io_line_oe_q[i]  <= out_cfg_q[i].en;
        io_line_out_q[i] <= out_cfg_q[i].en & cond_met[i];
      end
    end
  end

  property p_disabled_quiet;
    @(posedge clk) disable iff (!resetn)
      cmd_valid_q |-> $past(|hit) && $past(any_hit);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("cmd without enabled hit");

  property p_rise_once;
    @(posedge clk) disable iff (!resetn)
      (in_cfg_q[0].dtype == det_rise && hit[0]) ##1 (in_cfg_q[0].dtype == det_rise) |-> !hit[0];
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("rise fired twice");

  property p_pair_chans;
    @(posedge clk) disable iff (!resetn)
      cmd_valid_q && (cmd_q.action == pairing_series || cmd_q.action == pairing_parallel ||
      cmd_q.action == pairing_individual) |-> cmd_q.chans == `ETIO_PAIR_CHANS;
  endproperty
  a_pair_chans: assert property (p_pair_chans) else $error("pairing not on ch1/ch2");

  property p_resp_match;
    @(posedge clk) disable iff (!resetn)
      cmd_valid_q |-> cmd_q.action == $past(sel_resp);
  endproperty
  a_resp_match: assert property (p_resp_match) else $error("wrong response action");

  property p_readback;
    @(posedge clk) disable iff (!resetn)
      rd && addr == 8'h00 |=> rdata_q[`ETIO_IN_CFG_W-1:0] == $past(in_cfg_q[0]);
  endproperty
  a_readback: assert property (p_readback) else $error("config readback mismatch");

  property p_gt_volt;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_gt_v && out_cfg_q[0].chan == 2'h0 &&
      ch_meas[0].volt > thresh_q[0] |=> io_line_out_q[0];
  endproperty
  a_gt_volt: assert property (p_gt_volt) else $error("voltage trigger missed");

  property p_cond_output_disabled;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_output_disabled && out_cfg_q[0].chan == 2'h0
      |=> io_line_out_q[0] == !$past(ch_out_en[0]);
  endproperty
  a_cond_output_disabled: assert property (p_cond_output_disabled) else $error("output-off trigger wrong");

  property p_auto;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_auto && out_cfg_q[0].chan == 2'h0 &&
      ch_meas[0].volt > thresh_q[0] |=> io_line_out_q[0];
  endproperty
  a_auto: assert property (p_auto) else $error("auto trigger missed");

  // Further output-side checks on line 0, the line the bench drives through every condition
  property p_lt_curr;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_lt_c && out_cfg_q[0].chan == 2'h0 &&
      ch_meas[0].curr < thresh_q[0] |=> io_line_out_q[0];
  endproperty
  a_lt_curr: assert property (p_lt_curr) else $error("current trigger missed");

  property p_eq_pow;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_eq_p && out_cfg_q[0].chan == 2'h0 &&
      ch_meas[0].pow == thresh_q[0] |=> io_line_out_q[0];
  endproperty
  a_eq_pow: assert property (p_eq_pow) else $error("power trigger missed");

  property p_cond_output_enabled;
    @(posedge clk) disable iff (!resetn)
      out_cfg_q[0].en && out_cfg_q[0].cond == cond_output_enabled && out_cfg_q[0].chan == 2'h0
      |=> io_line_out_q[0] == $past(ch_out_en[0]);
  endproperty
  a_cond_output_enabled: assert property (p_cond_output_enabled) else $error("output-on trigger wrong");

  // A line whose output side is off must neither drive nor show a trigger
  property p_out_gated;
    @(posedge clk) disable iff (!resetn)
      !out_cfg_q[0].en |=> !io_line_oe_q[0] && !io_line_out_q[0];
  endproperty
  a_out_gated: assert property (p_out_gated) else $error("disabled line driven");

  // Input-side checks; high sensitivity takes a new level on its first differing cycle
  property p_filter_high;
    @(posedge clk) disable iff (!resetn)
      in_cfg_q[0].sens == sens_high && sync2_q[0] != filt_q[0] |=> filt_q[0] == $past(sync2_q[0]);
  endproperty
  a_filter_high: assert property (p_filter_high) else $error("fast filter too slow");

  property p_pair_refuse;
    @(posedge clk) disable iff (!resetn)
      any_hit && (sel_resp == pairing_individual || sel_resp == pairing_series ||
      sel_resp == pairing_parallel) && sel_chans[1:0] != 2'h3 |=> !cmd_valid_q;
  endproperty
  a_pair_refuse: assert property (p_pair_refuse) else $error("pairing without ch1/ch2");

  // Line 0 has top priority, so its hit must reach the command port when its set holds channels one and two
  property p_line0_wins;
    @(posedge clk) disable iff (!resetn)
      hit[0] && in_cfg_q[0].chans[1:0] == 2'h3
      |=> cmd_valid_q && cmd_q.action == $past(in_cfg_q[0].resp);
  endproperty
  a_line0_wins: assert property (p_line0_wins) else $error("line 0 hit lost");

  property p_state_both;
    @(posedge clk) disable iff (!resetn)
      in_cfg_q[4].en && in_cfg_q[4].dtype == det_state && filt_q[4] != prev_q[4] |-> hit[4];
  endproperty
  a_state_both: assert property (p_state_both) else $error("state change missed");

  property p_disabled_none;
    @(posedge clk) disable iff (!resetn)
      !in_cfg_q[0].en |-> !hit[0];
  endproperty
  a_disabled_none: assert property (p_disabled_none) else $error("disabled line hit");

endmodule

/* File: tb/etio_ext_model.sv */
// Purpose: Far-side equipment that drives the five trigger lines
// Assumes: Lines move just after a rising clock edge
// Notes:   Lines start low and hold until the bench moves them
`timescale 1ns/1ps
module etio_ext_model (
  input  wire logic       clk,
  output logic [4:0]      io_line
);
  // Idle level of every line; no pulls, so a real level is always driven
  initial io_line = 5'h00;

  // One line moves after the next edge, like a slow external source
  task automatic set_line(input int n, input logic v);
    @(posedge clk);
    io_line[n] <= v;
  endtask
endmodule

/* File: tb/etio_top_bench.sv */
// Purpose: Self-checking bench for the trigger line block
// Assumes: Register bus answers in the cycle after a read strobe
// Notes:   Input settings of lines 0, 2, 3 and 4 and the output side of line 0 are driven from this sequence
`timescale 1ns/1ps
module etio_top_bench;
  import etio_pkg::*;
  localparam logic [11:0] EXP_OUT = 12'hC45;
  logic        clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_q;
  logic [4:0]  io_line_in;
  logic [4:0]  io_line_out_q;
  logic [4:0]  io_line_oe_q;
  logic [2:0]  ch_out_en;
  etio_meas_t  ch_meas [3];
  logic        cmd_valid_q;
  etio_cmd_t   cmd_q;
  int          n_errors;
  int          n_tests;
  int          r;

  etio_top dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .io_line_in(io_line_in), .io_line_out_q(io_line_out_q),
    .io_line_oe_q(io_line_oe_q), .ch_out_en(ch_out_en), .ch_meas(ch_meas),
    .cmd_valid_q(cmd_valid_q), .cmd_q(cmd_q));
  etio_ext_model ext (.clk(clk), .io_line(io_line_in));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Data stand from the cycle after the strobe until the next read, so look there
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(what, exp, rdata_q);
  endtask

  function automatic logic [31:0] in_word(etio_resp_t rs, logic [2:0] ch, etio_sens_t s,
                                          etio_det_t t);
    return {19'h0, rs, ch, s, t, 1'b1};
  endfunction

  // Bounded wait for a command; lat 0 accepts any delay
  task automatic wait_cmd(input string what, input logic hit, input logic [3:0] act,
                          input logic [2:0] ch, input int lat);
    int k;
    for (k = 1; k <= 40; k++) begin
      @(posedge clk);
      #1;
      if (cmd_valid_q === 1'b1) break;
    end
    check({what, " fired"}, {31'h0, hit}, {31'h0, cmd_valid_q});
    if (hit && cmd_valid_q === 1'b1) begin
      check({what, " cmd"}, {25'h0, act, ch}, {25'h0, cmd_q});
      if (lat != 0) check({what, " latency"}, lat, k);
    end
  endtask

  task automatic out_chk(input string what, input logic [1:0] exp);
    repeat (3) @(posedge clk);
    #1;
    check(what, {30'h0, exp}, {30'h0, io_line_oe_q[0], io_line_out_q[0]});
  endtask

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    resetn    = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    wr        = 1'b0;
    rd        = 1'b0;
    ch_out_en = 3'h0;
    for (r = 0; r < 3; r++) ch_meas[r] = '0;
    n_errors  = 0;
    n_tests   = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (r = 0; r < 5; r++) begin
      rd_chk("in_cfg reset", 8'(r * 16), 32'h0000_0020);
      rd_chk("out_cfg reset", 8'(r * 16 + 4), 32'h0);
      rd_chk("thresh reset", 8'(r * 16 + 8), 32'h0);
    end
    wr_reg(8'h60, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h60, 32'h0);
    $display("test reset done");
    // Every response from a rising edge; pairing narrows to channels one and two
    for (r = 0; r < 10; r++) begin
      wr_reg(8'h00, in_word(etio_resp_t'(r), 3'h7, sens_high, det_rise));
      rd_chk("in_cfg", 8'h00, in_word(etio_resp_t'(r), 3'h7, sens_high, det_rise));
      ext.set_line(0, 1'b1);
      wait_cmd("rise", 1'b1, 4'(r), (r >= 7) ? 3'h3 : 3'h7, 4);
      @(posedge clk);
      #1;
      check("edge once", 32'h0, {31'h0, cmd_valid_q});
      ext.set_line(0, 1'b0);
      wait_cmd("fall on rise line", 1'b0, 4'h0, 3'h0, 0);
    end
    $display("test responses done");
    wr_reg(8'h00, in_word(resp_off, 3'h2, sens_high, det_rise));
    ext.set_line(0, 1'b1);
    wait_cmd("subset", 1'b1, resp_off, 3'h2, 4);
    ext.set_line(0, 1'b0);
    // Pairing without channel two in the set must give no command
    wr_reg(8'h00, in_word(pairing_series, 3'h1, sens_high, det_rise));
    ext.set_line(0, 1'b1);
    wait_cmd("pairing no ch2", 1'b0, 4'h0, 3'h0, 0);
    ext.set_line(0, 1'b0);
    wr_reg(8'h00, in_word(resp_on, 3'h1, sens_high, det_rise) & 32'hFFFF_FFFE);
    ext.set_line(0, 1'b1);
    wait_cmd("disabled", 1'b0, 4'h0, 3'h0, 0);
    ext.set_line(0, 1'b0);
    $display("test refusals done");
    // Low level repeats each cycle while it lasts
    wr_reg(8'h20, in_word(load_const_voltage, 3'h4, sens_mid, det_low));
    wait_cmd("low level", 1'b1, load_const_voltage, 3'h4, 0);
    repeat (3) begin
      @(posedge clk);
      #1;
      check("level repeat", 32'h1, {31'h0, cmd_valid_q});
    end
    ext.set_line(2, 1'b1);
    repeat (12) @(posedge clk);
    #1;
    check("level gone", 32'h0, {31'h0, cmd_valid_q});
    // Slow filter must swallow a glitch shorter than its length
    wr_reg(8'h30, in_word(resp_toggle, 3'h1, sens_low, det_fall));
    ext.set_line(3, 1'b1);
    wait_cmd("rise on fall line", 1'b0, 4'h0, 3'h0, 0);
    ext.set_line(3, 1'b0);
    repeat (8) @(posedge clk);
    ext.set_line(3, 1'b1);
    wait_cmd("short glitch", 1'b0, 4'h0, 3'h0, 0);
    ext.set_line(3, 1'b0);
    wait_cmd("long low", 1'b1, resp_toggle, 3'h1, 0);
    wr_reg(8'h40, in_word(resp_power, 3'h4, sens_high, det_state));
    ext.set_line(4, 1'b1);
    wait_cmd("state up", 1'b1, resp_power, 3'h4, 4);
    ext.set_line(4, 1'b0);
    wait_cmd("state down", 1'b1, resp_power, 3'h4, 4);
    $display("test detection done");
    // Output conditions on line 0 against channel one readings
    ch_meas[0] <= '{volt: 16'h0200, curr: 16'h0080, pow: 16'h0100};
    wr_reg(8'h08, 32'h0000_0100);
    rd_chk("thresh", 8'h08, 32'h0000_0100);
    for (r = 0; r < 12; r++) begin
      wr_reg(8'h04, {25'h0, 2'h0, 4'(r), 1'b1});
      out_chk("out cond", {1'b1, EXP_OUT[r]});
    end
    ch_out_en <= 3'h1;
    wr_reg(8'h08, 32'h0000_FFFF);
    wr_reg(8'h04, 32'h0000_0003);
    out_chk("cond_output_enabled", 2'h3);
    wr_reg(8'h04, 32'h0000_0002);
    out_chk("out disabled", 2'h0);
    $display("test output done");
    finish_test();
  end
endmodule
